// *** hdl/irq_map.svh ***
// register offsets, field positions, reset values and vector addresses
// Functional notes
// - four maskable sources plus one non-maskable, each with its own fixed vector
// - maskable service only while global enable set; events still latched meanwhile
// - accepted request loads the core program counter with the source vector address
// - several event lines may be ORed onto one vector; flags tell the cause
// - reset acts at any time, also inside any service routine
// - non-maskable has top priority, preempts maskable, never another non-maskable
// - maskable never preempts maskable; pending ones granted vector 1 down to 4
// - every interrupt source wakes the processor from WAIT; here non-maskable wakes only while global enable set
// - only pin and designated peripheral sources wake from STOP
// - falling edge on non-maskable pin requests vector 0 regardless of global enable
// - vector 0 latch is cleared by the core at start of its routine
// - peripheral flag requests only when global enable and its own enable set
// - peripheral requests on vectors 3 and 4 held by flags until software clears
// - pin interrupts on vectors 1 and 2, need global enable, wake from STOP
// - vector 1 is edge or level sensitive per the level/edge select bit
// - vector 2 always edge sensitive, polarity from the edge polarity bit
// - edge latch set by edge, cleared at routine start; only first arrival kept
// - level mode stores nothing; pin must be low when sampled after an instruction
// - reset sets interrupt mode as if non-maskable; only return instruction clears
// - global enable is bit 4 of write-only option register at 0C8h, reset 00h
// - option bit 6: 0 falling edge, 1 low level for vector 1
// - option bit 5: 0 falling, 1 rising edge for vector 2
// - vectors FFE,FFC,FF6,FF4,FF2,FF0; vector 4 does not wake from STOP
`ifndef IRQ_MAP_SVH
`define IRQ_MAP_SVH
`define OPT_REG_OFS      8'hC8
`define STAT_REG_OFS     8'hCC
`define OPT_RESET        8'h00
`define OPT_LES_BIT      6
`define OPT_ESB_BIT      5
`define OPT_GEN_BIT      4
`define STAT_NMI_BIT     0
`define STAT_V1_BIT      1
`define STAT_V2_BIT      2
`define STAT_MODE_LSB    4
`define VEC_RESET        12'hFFE
`define VEC0_ADDR        12'hFFC
`define VEC1_ADDR        12'hFF6
`define VEC2_ADDR        12'hFF4
`define VEC3_ADDR        12'hFF2
`define VEC4_ADDR        12'hFF0
`define AXI_OKAY         2'h0
`define AXI_DECERR       2'h3
`endif

// *** hdl/irq_pkg.sv ***
// types shared by the interrupt controller files
package irq_pkg;
    typedef enum logic [1:0] {
        MODE_NORMAL = 2'b00,
        MODE_MASK   = 2'b01,
        MODE_NMI    = 2'b10
    } irq_mode_e;
    typedef logic [2:0]  vec_num_t;
    typedef logic [11:0] vec_addr_t;
endpackage

// *** hdl/pin_sync.sv ***
// two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 1
) (
    input  wire logic         clock_in,   // core clock
    input  wire logic         sys_rst_in, // sync reset, high
    input  wire logic [W-1:0] d_in,       // raw pin levels
    output logic      [W-1:0] q_out       // synchronised levels
);
    logic [W-1:0] meta_r;

    // pins idle high (pull-ups), so reset to ones avoids a false falling edge
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            meta_r <= '1;
            q_out  <= '1;
        end else begin
            meta_r <= d_in;
            q_out  <= meta_r;
        end
    end
endmodule

// *** hdl/mcu_interrupt_controller.sv ***
// interrupt request, priority, mode and wake logic with AXI4-Lite option register
`timescale 1ns/1ps
`include "irq_map.svh"
module mcu_interrupt_controller
    import irq_pkg::*;
#(
    parameter int W1 = 8,  // pins on vector 1
    parameter int W2 = 12, // pins on vector 2
    parameter int N3 = 1,  // peripheral events on vector 3
    parameter int N4 = 1   // peripheral events on vector 4
) (
    input  wire logic          clock_in,      // 250 MHz core clock
    input  wire logic          sys_rst_in,    // sync reset, high
    input  wire logic          nmi_pin_in,    // non-maskable pin, async
    input  wire logic [W1-1:0] v1_pins_in,    // vector 1 pins, async
    input  wire logic [W1-1:0] v1_pin_en_in,  // vector 1 pin interrupt enables
    input  wire logic [W2-1:0] v2_pins_in,    // vector 2 pins, async
    input  wire logic [W2-1:0] v2_pin_en_in,  // vector 2 pin interrupt enables
    input  wire logic [N3-1:0] v3_flags_in,   // vector 3 peripheral flags
    input  wire logic [N3-1:0] v3_en_in,      // vector 3 peripheral enables
    input  wire logic [N4-1:0] v4_flags_in,   // vector 4 peripheral flags
    input  wire logic [N4-1:0] v4_en_in,      // vector 4 peripheral enables
    input  wire logic          instr_done_in, // pulse: instruction completed
    input  wire logic          ack_in,        // pulse: core starts routine
    input  wire logic          return_from_interrupt_instr_in,       // pulse: return instruction
    input  wire logic          wait_in,       // level: core in WAIT
    input  wire logic          stop_in,       // level: core in STOP
    output logic               irq_req_out,   // request to core
    output vec_num_t           vec_num_out,   // granted vector number
    output vec_addr_t          vec_addr_out,  // address for program counter
    output irq_mode_e          mode_out,      // current interrupt mode
    output logic               wake_out,      // leave low-power state
    input  wire logic [7:0]    s_axi_awaddr,  // write address
    input  wire logic          s_axi_awvalid, // write address valid
    output logic               s_axi_awready, // write address ready
    input  wire logic [31:0]   s_axi_wdata,   // write data
    input  wire logic [3:0]    s_axi_wstrb,   // write strobes
    input  wire logic          s_axi_wvalid,  // write data valid
    output logic               s_axi_wready,  // write data ready
    output logic [1:0]         s_axi_bresp,   // write response
    output logic               s_axi_bvalid,  // write response valid
    input  wire logic          s_axi_bready,  // write response ready
    input  wire logic [7:0]    s_axi_araddr,  // read address
    input  wire logic          s_axi_arvalid, // read address valid
    output logic               s_axi_arready, // read address ready
    output logic [31:0]        s_axi_rdata,   // read data
    output logic [1:0]         s_axi_rresp,   // read response
    output logic               s_axi_rvalid,  // read data valid
    input  wire logic          s_axi_rready   // read data ready
);
    // ----------------------------------------------------------------
    // functions
    // ----------------------------------------------------------------
    function automatic vec_addr_t vec_addr(input vec_num_t n);
        vec_addr_t a;
        a = `VEC4_ADDR;
        unique case (n)
            3'd0:    a = `VEC0_ADDR;
            3'd1:    a = `VEC1_ADDR;
            3'd2:    a = `VEC2_ADDR;
            3'd3:    a = `VEC3_ADDR;
            default: a = `VEC4_ADDR;
        endcase
        return a;
    endfunction

    // ----------------------------------------------------------------
    // pin synchronisers and combined lines
    // ----------------------------------------------------------------
    logic [W1-1:0] v1_sync;
    logic [W2-1:0] v2_sync;
    logic          nmi_sync;
    logic [7:0]    opt_r;
    logic          gen, vec1_level_edge_select, vec2_edge_polarity;
    logic          line1, line2;
    logic          nmi_d_r, line2_d_r, line1_d_r;
    logic          nmi_fall, v1_fall, v2_edge;

    pin_sync #(.W(1)) u_nmi_sync (
        .clock_in   (clock_in),
        .sys_rst_in (sys_rst_in),
        .d_in       (nmi_pin_in),
        .q_out      (nmi_sync)
    );
    pin_sync #(.W(W1 + W2)) u_port_sync (
        .clock_in   (clock_in),
        .sys_rst_in (sys_rst_in),
        .d_in       ({v1_pins_in, v2_pins_in}),
        .q_out      ({v1_sync, v2_sync})
    );

    assign gen = opt_r[`OPT_GEN_BIT];
    assign vec1_level_edge_select = opt_r[`OPT_LES_BIT];
    assign vec2_edge_polarity = opt_r[`OPT_ESB_BIT];
    // enabled pins are wired together onto one line per vector
    assign line1 = &(v1_sync | ~v1_pin_en_in);
    assign line2 = vec2_edge_polarity ? |(v2_sync & v2_pin_en_in)
                       : &(v2_sync | ~v2_pin_en_in);

    // previous line levels for edge detection
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            nmi_d_r   <= 1'b1;
            line1_d_r <= 1'b1;
            line2_d_r <= 1'b1;
        end else begin
            nmi_d_r   <= nmi_sync;
            line1_d_r <= line1;
            line2_d_r <= line2;
        end
    end
    assign nmi_fall = nmi_d_r & ~nmi_sync;
    assign v1_fall  = line1_d_r & ~line1;
    // a polarity flip with enabled pins at mixed levels reads as an edge on the new line form and is latched
    assign v2_edge  = vec2_edge_polarity ? (~line2_d_r & line2) : (line2_d_r & ~line2);

    // ----------------------------------------------------------------
    // request latches and pending terms
    // ----------------------------------------------------------------
    logic      nmi_lat_r, v1_lat_r, v2_lat_r;
    logic      served;
    logic      p1, p2, p3, p4, v3_any, v4_any;
    irq_mode_e mode_r;
    logic      nested_r;

    assign served = ack_in & irq_req_out;
    assign v3_any = |(v3_flags_in & v3_en_in);
    assign v4_any = |(v4_flags_in & v4_en_in);
    // level mode stores nothing: the line itself is the request
    assign p1 = vec1_level_edge_select ? ~line1 : v1_lat_r;
    assign p2 = v2_lat_r;
    assign p3 = v3_any;
    assign p4 = v4_any;

    // the edge wins over the clearing acknowledge in the same cycle
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            nmi_lat_r <= 1'b0;
        end else if (nmi_fall) begin
            nmi_lat_r <= 1'b1;
        end else if (served && vec_num_out == 3'd0) begin
            nmi_lat_r <= 1'b0;
        end
    end

    // a second edge while set is absorbed: only the first is kept
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            v1_lat_r <= 1'b0;
        end else if (vec1_level_edge_select) begin
            v1_lat_r <= 1'b0;
        end else if (v1_fall) begin
            v1_lat_r <= 1'b1;
        end else if (served && vec_num_out == 3'd1) begin
            v1_lat_r <= 1'b0;
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            v2_lat_r <= 1'b0;
        end else if (v2_edge) begin
            v2_lat_r <= 1'b1;
        end else if (served && vec_num_out == 3'd2) begin
            v2_lat_r <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // arbitration, sampled after each instruction
    // ----------------------------------------------------------------
    logic     take_nxt;
    vec_num_t num_nxt;
    logic     mask_ok;

    assign mask_ok = gen && mode_r == MODE_NORMAL;
    always_comb begin
        take_nxt = 1'b1;
        num_nxt  = 3'd0;
        if (nmi_lat_r && mode_r != MODE_NMI) begin
            num_nxt = 3'd0;
        end else if (mask_ok && p1) begin
            num_nxt = 3'd1;
        end else if (mask_ok && p2) begin
            num_nxt = 3'd2;
        end else if (mask_ok && p3) begin
            num_nxt = 3'd3;
        end else if (mask_ok && p4) begin
            num_nxt = 3'd4;
        end else begin
            take_nxt = 1'b0;
        end
    end

    // request stands until the core acks or the next sample point
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            irq_req_out  <= 1'b0;
            vec_num_out  <= 3'd0;
            vec_addr_out <= `VEC_RESET;
        end else if (served) begin
            irq_req_out <= 1'b0;
        end else if (instr_done_in) begin
            irq_req_out  <= take_nxt;
            vec_num_out  <= num_nxt;
            vec_addr_out <= vec_addr(num_nxt);
        end
    end

    // ----------------------------------------------------------------
    // interrupt mode
    // ----------------------------------------------------------------
    // reset behaves as a non-maskable routine so initialisation is safe
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            mode_r   <= MODE_NMI;
            nested_r <= 1'b0;
        end else if (served) begin
            mode_r   <= (vec_num_out == 3'd0) ? MODE_NMI : MODE_MASK;
            nested_r <= (vec_num_out == 3'd0) && mode_r == MODE_MASK;
        end else if (return_from_interrupt_instr_in) begin
            mode_r   <= nested_r ? MODE_MASK : MODE_NORMAL;
            nested_r <= 1'b0;
        end
    end
    assign mode_out = mode_r;

    // ----------------------------------------------------------------
    // wake from WAIT and STOP
    // ----------------------------------------------------------------
    // non-maskable cannot wake while the global enable is clear
    logic wake_any, wake_stop;
    assign wake_any  = gen & (nmi_lat_r | p1 | p2 | p3 | p4);
    assign wake_stop = gen & (nmi_lat_r | p1 | p2 | p3);
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            wake_out <= 1'b0;
        end else begin
            wake_out <= (wait_in & wake_any) | (stop_in & wake_stop);
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------------------------------
    logic       aw_hold_r, w_hold_r;
    logic [7:0] awaddr_r;
    logic [7:0] wdata_r;
    logic       wstrb0_r;
    logic       do_write;

    assign s_axi_awready = ~aw_hold_r & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_hold_r & ~s_axi_bvalid;
    assign do_write      = aw_hold_r & w_hold_r & ~s_axi_bvalid;

    // address and data are taken in either order and held
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            aw_hold_r <= 1'b0;
            w_hold_r  <= 1'b0;
            awaddr_r  <= 8'h00;
            wdata_r   <= 8'h00;
            wstrb0_r  <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_r <= 1'b1;
                awaddr_r  <= s_axi_awaddr;
            end else if (do_write) begin
                aw_hold_r <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_r <= 1'b1;
                wdata_r  <= s_axi_wdata[7:0];
                wstrb0_r <= s_axi_wstrb[0];
            end else if (do_write) begin
                w_hold_r <= 1'b0;
            end
        end
    end

    // option register: bits 7 and 3:0 are kept clear
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            opt_r <= `OPT_RESET;
        end else if (do_write && awaddr_r == `OPT_REG_OFS && wstrb0_r) begin
            opt_r <= wdata_r & 8'h70;
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `AXI_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awaddr_r == `OPT_REG_OFS || awaddr_r == `STAT_REG_OFS)
                            ? `AXI_OKAY : `AXI_DECERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // reads: option register is write-only and reads zero
    assign s_axi_arready = ~s_axi_rvalid;
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `AXI_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `AXI_OKAY;
            if (s_axi_araddr == `STAT_REG_OFS) begin
                s_axi_rdata[`STAT_NMI_BIT] <= nmi_lat_r;
                s_axi_rdata[`STAT_V1_BIT]  <= v1_lat_r;
                s_axi_rdata[`STAT_V2_BIT]  <= v2_lat_r;
                s_axi_rdata[`STAT_MODE_LSB +: 2] <= mode_r;
            end else if (s_axi_araddr != `OPT_REG_OFS) begin
                s_axi_rresp <= `AXI_DECERR;
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    chk_nmi_latch_set: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        nmi_fall |=> nmi_lat_r)
        else $error("nmi edge not latched");
    chk_vec_addr_map: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        irq_req_out |-> vec_addr_out == ((vec_num_out == 3'd0) ? `VEC0_ADDR
                        : `VEC1_ADDR - {8'h00, vec_num_out, 1'b0} + 12'h002))
        else $error("vector address mismatch");
    chk_gen_masks: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        instr_done_in && !served && !gen |=> !irq_req_out || vec_num_out == 3'd0)
        else $error("maskable request with global enable clear");
    chk_no_mask_nest: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        instr_done_in && !served && mode_r == MODE_MASK |=> !irq_req_out || vec_num_out == 3'd0)
        else $error("maskable nested in maskable");
    chk_nmi_no_nest: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        instr_done_in && !served && mode_r == MODE_NMI |=> !irq_req_out)
        else $error("request granted inside nmi routine");
    chk_reset_mode: assert property (@(posedge clock_in)
        sys_rst_in |=> mode_r == MODE_NMI && !irq_req_out)
        else $error("reset did not enter nmi mode");
    chk_v1_before_v2: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        instr_done_in && !served && mask_ok && p1 && !nmi_lat_r |=> vec_num_out == 3'd1)
        else $error("vector 1 priority lost");
    chk_ack_clears_v2: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        served && vec_num_out == 3'd2 && !v2_edge |=> !v2_lat_r)
        else $error("vector 2 latch not cleared");
    chk_stop_no_v4: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        stop_in && !wait_in && !(nmi_lat_r | p1 | p2 | p3) |=> !wake_out)
        else $error("stop woken by non-waking source");
    chk_wait_wake: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        wait_in && gen && p4 |=> wake_out)
        else $error("wait not left on request");
    cov_nmi_preempt: cover property (@(posedge clock_in) disable iff (sys_rst_in)
        served && vec_num_out == 3'd0 && mode_r == MODE_MASK);
    cov_v1_taken: cover property (@(posedge clock_in) disable iff (sys_rst_in)
        served && vec_num_out == 3'd1);
    cov_v4_taken: cover property (@(posedge clock_in) disable iff (sys_rst_in)
        served && vec_num_out == 3'd4);
    cov_stop_wake: cover property (@(posedge clock_in) disable iff (sys_rst_in)
        stop_in && wake_out);
endmodule

// *** verif/core_model.sv ***
// behavioural cpu core: instruction ticks and routine-start acknowledge
`timescale 1ns/1ps
module core_model (
    input  wire logic clock_in,   // core clock
    input  wire logic sys_rst_in, // sync reset, high
    input  wire logic irq_req_in, // request from controller
    input  wire logic frozen_in,  // wait or stop: no instructions run
    output logic      done_out,   // pulse: instruction completed
    output logic      ack_out     // pulse: routine start
);
    logic [1:0] tick_r; // four-cycle instruction length
    // a frozen core samples nothing, so grants only follow a wake and release
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            tick_r   <= 2'h0;
            done_out <= 1'b0;
            ack_out  <= 1'b0;
        end else begin
            tick_r   <= tick_r + 2'h1;
            done_out <= !frozen_in && tick_r == 2'h3;
            ack_out  <= irq_req_in && !ack_out && !frozen_in;
        end
    end
endmodule

// *** verif/mcu_interrupt_controller_tb.sv ***
// self-checking bench for the interrupt controller
`timescale 1ns/1ps
`include "irq_map.svh"
module mcu_interrupt_controller_tb
    import irq_pkg::*;
;
    logic        clock_in = 1'b0, sys_rst_in = 1'b1, nmi = 1'b1, return_from_interrupt_instr = 1'b0, wt = 1'b0;
    logic        stp = 1'b0, en3 = 1'b0, f3 = 1'b0, f4 = 1'b0, req, wake, dn, ack;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [7:0]  p1 = 8'hFF, s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [11:0] p2 = 12'hFFF;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    vec_addr_t   va, exp_a;
    irq_mode_e   md;
    vec_num_t    vn;
    logic [31:0] exp_n;
    logic [11:0] exp_q[$];
    vec_addr_t   tbl[4] = '{12'hFF6, 12'hFF4, 12'hFF0, 12'hFF2};
    int          n_mismatch = 0, cmp_count = 0, n_ack = 0, want = 0, cyc = 0;
    int          seed = 87859, idx;
    mcu_interrupt_controller mcu_interrupt_controller_inst (.clock_in, .sys_rst_in,
        .nmi_pin_in(nmi), .v1_pins_in(p1), .v1_pin_en_in(8'hFF), .v2_pins_in(p2),
        .v2_pin_en_in(12'hFFF), .v3_flags_in(f3), .v3_en_in(en3), .v4_flags_in(f4),
        .v4_en_in(1'b1), .instr_done_in(dn), .ack_in(ack), .return_from_interrupt_instr_in(return_from_interrupt_instr), .wait_in(wt),
        .stop_in(stp), .irq_req_out(req), .vec_num_out(vn), .vec_addr_out(va), .mode_out(md),
        .wake_out(wake), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    core_model core_model_inst (.clock_in, .sys_rst_in, .irq_req_in(req),
        .frozen_in(wt | stp), .done_out(dn), .ack_out(ack));
    always #2 clock_in = ~clock_in;
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        if (n_mismatch == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock_in);
    endtask
    task automatic push(input vec_addr_t a);
        exp_q.push_back(a);
        want++;
    endtask
    // wait for the core to take every noted request, then let mode settle
    task automatic hold();
        while (n_ack < want) tick(1);
        tick(1);
    endtask
    task automatic ret();
        return_from_interrupt_instr <= 1'b1;
        tick(1);
        return_from_interrupt_instr <= 1'b0;
        tick(1);
    endtask
    task automatic nmi_dip();
        nmi <= 1'b0;
        tick(3);
        nmi <= 1'b1;
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clock_in);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk("bresp", 32'(s_axi_bresp), 32'(`AXI_OKAY));
    endtask
    task automatic axi_rd(input logic [7:0] a, input logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clock_in);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        // rready stays high: a back-to-back read would otherwise drive it twice in one step
        chk("rdata", s_axi_rdata, 32'h0);
        chk("rresp", 32'(s_axi_rresp), 32'(r));
    endtask
    // ---------------------------------------------------------------
    // watcher: every routine start is matched to the oldest note
    // ---------------------------------------------------------------
    always @(posedge clock_in) begin
        if (++cyc > 20000) begin
            n_mismatch++;
            report_and_stop();
        end
        if (ack === 1'b1 && req === 1'b1) begin
            n_ack++;
            if (exp_q.size() == 0) chk("spurious", 32'h1, 32'h0);
            else begin
                exp_a = exp_q.pop_front();
                // vector slots sit two bytes apart below the vector 1 slot
                exp_n = (exp_a == `VEC0_ADDR) ? 32'h0
                      : (32'(`VEC1_ADDR) - 32'(exp_a)) / 32'h2 + 32'h1;
                chk("vector", 32'(va), 32'(exp_a));
                chk("vec_num", 32'(vn), exp_n);
            end
        end
    end
    initial begin
        tick(3);
        sys_rst_in <= 1'b0;
        tick(1);
        chk("mode", 32'(md), 32'(MODE_NMI));
        chk("vector", 32'(va), 32'(`VEC_RESET));
        idx = $unsigned($random(seed)) % 8;
        f3 <= 1'b1;
        f4 <= 1'b1;
        p1[idx] <= 1'b0;
        p2[idx] <= 1'b0;
        nmi_dip();
        p1 <= 8'hFF;
        p2 <= 12'hFFF;
        tick(12);
        chk("req", 32'(req), 32'h0);
        push(`VEC0_ADDR);
        ret();
        hold();
        chk("mode", 32'(md), 32'(MODE_NMI));
        ret();
        axi_rd(`OPT_REG_OFS, `AXI_OKAY);
        axi_rd(8'h40, `AXI_DECERR);
        push(tbl[0]);
        axi_wr(`OPT_REG_OFS, 32'h10);
        // pending edges, then vector 4 flag, then vector 3 flag once its enable is set
        for (int i = 0; i < 4; i++) begin
            if (i > 0) push(tbl[i]);
            hold();
            chk("mode", 32'(md), 32'(MODE_MASK));
            if (i == 0) begin
                push(`VEC0_ADDR);
                nmi_dip();
                hold();
                chk("mode", 32'(md), 32'(MODE_NMI));
                nmi_dip();
                tick(12);
                chk("req", 32'(req), 32'h0);
                push(`VEC0_ADDR);
                ret();
                hold();
                ret();
                chk("mode", 32'(md), 32'(MODE_MASK));
            end
            if (i == 2) f4 <= 1'b0;
            if (i == 2) en3 <= 1'b1;
            if (i == 3) f3 <= 1'b0;
            ret();
        end
        stp <= 1'b1;
        f4 <= 1'b1;
        tick(6);
        chk("wake", 32'(wake), 32'h0);
        stp <= 1'b0;
        wt <= 1'b1;
        tick(6);
        chk("wake", 32'(wake), 32'h1);
        wt <= 1'b0;
        push(`VEC4_ADDR);
        hold();
        f4 <= 1'b0;
        ret();
        axi_wr(`OPT_REG_OFS, 32'h50);
        p1[idx] <= 1'b0;
        push(`VEC1_ADDR);
        hold();
        p1 <= 8'hFF;
        // released pin must clear the synchroniser before normal mode resumes
        tick(3);
        ret();
        tick(12);
        chk("req", 32'(req), 32'h0);
        axi_wr(`OPT_REG_OFS, 32'h30);
        p2 <= 12'h000;
        tick(12);
        chk("req", 32'(req), 32'h0);
        p2 <= 12'hFFF;
        push(`VEC2_ADDR);
        hold();
        ret();
        f3 <= 1'b1;
        push(`VEC3_ADDR);
        hold();
        // reset in mid-routine must restore nmi mode and a cleared option byte
        sys_rst_in <= 1'b1;
        tick(3);
        sys_rst_in <= 1'b0;
        tick(1);
        chk("mode", 32'(md), 32'(MODE_NMI));
        ret();
        tick(12);
        chk("req", 32'(req), 32'h0);
        report_and_stop();
    end
endmodule
